// ---- hw/nid_pkg.sv ----
// constants, field layouts and opcodes of the instruction decoder
package nid_pkg;
  // ---------------------------------------------------------------
  // field layout of a 16-bit instruction word
  // ---------------------------------------------------------------
  localparam int OP_MSB     = 15;
  localparam int OP_LSB     = 11;
  localparam int ROW_MSB    = 10;
  localparam int ROW_LSB    = 8;
  localparam int COL_MSB    = 7;
  localparam int COL_LSB    = 4;
  localparam int LOW_MSB    = 3;
  localparam int LOW_LSB    = 0;
  localparam int ADDR_MSB   = 10;
  localparam int ADDR_LSB   = 0;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [4:0] OP_ADD_RM   = 5'h00;
  localparam logic [4:0] OP_SUB_RM   = 5'h01;
  localparam logic [4:0] OP_ADD_CARRY_RM  = 5'h02;
  localparam logic [4:0] OP_SUBTRACT_BORROW_RM  = 5'h03;
  localparam logic [4:0] OP_OR_RM    = 5'h06;
  localparam logic [4:0] OP_EXT      = 5'h07;
  localparam logic [4:0] OP_BR       = 5'h0c;
  localparam logic [4:0] OP_ADD_MI   = 5'h10;
  localparam logic [4:0] OP_SUB_MI   = 5'h11;
  localparam logic [4:0] OP_ADD_CARRY_MI  = 5'h12;
  localparam logic [4:0] OP_SUBTRACT_BORROW_MI  = 5'h13;
  localparam logic [4:0] OP_CALL     = 5'h1c;
  localparam logic [4:0] OP_SKT      = 5'h1e;
  localparam logic [4:0] OP_SKF      = 5'h1f;
  // extended-group column codes
  localparam logic [3:0] COL_TBL     = 4'h1;
  localparam logic [3:0] COL_PEEK    = 4'h3;
  localparam logic [3:0] COL_BR_AR   = 4'h4;
  localparam logic [3:0] COL_CALL_AR = 4'h5;
  localparam logic [3:0] COL_INC_IX  = 4'h8;
  localparam logic [3:0] COL_INC_AR  = 4'h9;
  localparam logic [3:0] COL_PUT     = 4'ha;
  localparam logic [3:0] COL_GET     = 4'hb;
  localparam logic [3:0] COL_RET     = 4'he;
  localparam logic [2:0] ROW_PLAIN   = 3'h0;
  localparam logic [2:0] ROW_RETI    = 3'h4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_NIB     = 4'h0;
  localparam logic [6:0] RST_ADDR7   = 7'h00;
  localparam logic [10:0] RST_PC     = 11'h000;
  localparam logic [2:0] RST_SP      = 3'h0;
  // datapath operations
  typedef enum logic [3:0] {
    NID_ALU_NONE = 4'h0,
    NID_ALU_ADD  = 4'h1,
    NID_ALU_SUB  = 4'h2,
    NID_ALU_OR   = 4'h4
  } nid_alu_t;
  // fetch sequencing
  typedef enum logic [1:0] {
    NID_ST_RUN  = 2'b01,
    NID_ST_TBL2 = 2'b10
  } nid_state_t;
endpackage

// ---- hw/nid_decode.sv ----
// instruction decoder and nibble datapath control of the 4-bit core
`timescale 1ns/1ps
// Functional notes
// - branch and call targets come from the 11-bit field with its top bit forced to zero.
// - immediates of memory-with-constant forms are the low nibble of the word.
// - bit test forms carry a 4-bit mask selecting the examined memory bits.
// - peripheral address is a 3-bit upper field joined to a 4-bit lower field.
// - register file address is a 3-bit row field joined to a 4-bit low field.
// - data memory address is the row select above the column select.
// - subtract uses opcode 00001 into register and 10001 into memory.
// - subtract-with-borrow also deducts carry, opcodes 00011 and 10011.
// - opcode 00111 row 000 increments the address register on column 1001, index on 1000.
// - opcode 00110 ors memory into the register.
// - interrupt entry in the run state pushes the saved-state register onto the interrupt stack; in the second table fetch cycle it is ignored.
// - return addresses live in a stack whose entry the stack pointer selects.
// - the table fetch into the data buffer takes two instruction cycles.
module nid_decode (
  input  wire logic         clk,              // 40 MHz instruction clock
  input  wire logic         reset,            // async, active high
  input  wire logic         insn_valid,       // instruction word present this cycle
  input  wire logic [15:0]  insn,             // word from program memory
  input  wire logic [3:0]   reg_nibble,       // general register read data
  input  wire logic [3:0]   mem_nibble,       // data memory read data
  input  wire logic         irq_enter,        // interrupt entry pulse
  input  wire logic [3:0]   interrupt_saved_state, // state to save on entry
  output logic              insn_ready,       // low while table fetch holds the core
  output logic [6:0]        mem_addr,         // data memory address
  output logic [3:0]        reg_col,          // general register column
  output logic [3:0]        imm_nibble,       // immediate field
  output logic [3:0]        bit_mask,         // bit test mask
  output logic [6:0]        periph_addr,      // peripheral address
  output logic [6:0]        regfile_addr,     // register file address
  output logic [10:0]       branch_target,    // branch or call target
  output logic [3:0]        result_reg,       // alu result
  output logic              wr_reg,           // write result to register
  output logic              wr_mem,           // write result to memory
  output logic              carry_flag,       // carry / borrow flag
  output logic [10:0]       address_register, // address register
  output logic [3:0]        index_register,   // index register
  output logic [10:0]       pc_reg,           // program counter
  output logic [10:0]       stack_return_slot,// stack entry at stack pointer
  output logic [2:0]        sp_reg,           // stack pointer
  output logic [3:0]        interrupt_saved_state_stack_top,   // top of interrupt stack
  output logic [15:0]       data_buffer_reg,  // data buffer
  output logic              tbl_busy          // second table fetch cycle
);
  import nid_pkg::*;

  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  logic [4:0] op;
  logic [2:0] row_select;
  logic [3:0] column_select;
  logic [3:0] low_f;
  assign op            = insn[OP_MSB:OP_LSB];
  assign row_select    = insn[ROW_MSB:ROW_LSB];
  assign column_select = insn[COL_MSB:COL_LSB];
  assign low_f         = insn[LOW_MSB:LOW_LSB];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  nid_state_t  st_reg, st_next;
  logic [6:0]  mem_addr_reg, mem_addr_next;
  logic [3:0]  reg_col_reg, reg_col_next, imm_reg, imm_next, mask_reg, mask_next;
  logic [6:0]  per_reg, per_next, rf_reg, rf_next;
  logic [10:0] tgt_reg, tgt_next;
  logic [3:0]  res_reg, res_next;
  logic        wr_reg_reg, wr_reg_next, wr_mem_reg, wr_mem_next;
  logic        cy_reg, cy_next;
  logic [10:0] ar_reg, ar_next, pc_next, ret_pc_reg;
  logic [3:0]  ix_reg, ix_next;
  logic [2:0]  sp_next;
  logic [15:0] dbf_reg, dbf_next;
  logic [10:0] astack [0:7];
  logic [3:0]  istack [0:7];
  logic [2:0]  isp_reg, isp_next;
  logic        push, pop;
  nid_alu_t    alu;
  logic        use_cy, to_mem;
  logic [4:0]  sum;
  logic [3:0]  opb;

  // ---------------------------------------------------------------
  // decode and datapath
  // ---------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    mem_addr_next = {row_select, column_select};
    reg_col_next  = low_f;
    imm_next      = low_f;
    mask_next     = low_f;
    per_next      = {row_select, low_f};
    rf_next       = {row_select, low_f};
    tgt_next      = {1'b0, insn[ADDR_MSB-1:ADDR_LSB]};
    res_next      = res_reg;
    wr_reg_next   = 1'b0;
    wr_mem_next   = 1'b0;
    cy_next       = cy_reg;
    ar_next       = ar_reg;
    ix_next       = ix_reg;
    pc_next       = pc_reg;
    sp_next       = sp_reg;
    dbf_next      = dbf_reg;
    isp_next      = isp_reg;
    push          = 1'b0;
    pop           = 1'b0;
    alu           = NID_ALU_NONE;
    use_cy        = 1'b0;
    to_mem        = op[4];
    case (op)
      OP_ADD_RM, OP_ADD_MI:   alu = NID_ALU_ADD;
      OP_ADD_CARRY_RM, OP_ADD_CARRY_MI: begin
        alu    = NID_ALU_ADD;
        use_cy = 1'b1;
      end
      OP_SUB_RM, OP_SUB_MI:   alu = NID_ALU_SUB;
      OP_SUBTRACT_BORROW_RM, OP_SUBTRACT_BORROW_MI: begin
        alu    = NID_ALU_SUB;
        use_cy = 1'b1;
      end
      OP_OR_RM:               alu = NID_ALU_OR;
      default:                alu = NID_ALU_NONE;
    endcase
    // register forms take memory as the second operand, memory forms the immediate
    opb = to_mem ? low_f : mem_nibble;
    sum = 5'h00;
    case (alu)
      NID_ALU_ADD: sum = {1'b0, to_mem ? mem_nibble : reg_nibble} + {1'b0, opb}
                         + {4'h0, use_cy & cy_reg};
      NID_ALU_SUB: sum = {1'b0, to_mem ? mem_nibble : reg_nibble} - {1'b0, opb}
                         - {4'h0, use_cy & cy_reg};
      NID_ALU_OR:  sum = {1'b0, reg_nibble | mem_nibble};
      default:     sum = 5'h00;
    endcase
    case (st_reg)
      NID_ST_RUN: begin
        if (insn_valid) begin
          pc_next = pc_reg + 11'h001;
          if (alu != NID_ALU_NONE) begin
            res_next    = sum[3:0];
            wr_reg_next = ~to_mem;
            wr_mem_next = to_mem;
            if (alu != NID_ALU_OR)
              cy_next = sum[4];
          end
          if (op == OP_BR)
            pc_next = tgt_next;
          if (op == OP_CALL) begin
            push    = 1'b1;
            sp_next = sp_reg - 3'h1;
            pc_next = tgt_next;
          end
          if (op == OP_EXT) begin
            case (column_select)
              COL_INC_AR: if (row_select == ROW_PLAIN) ar_next = ar_reg + 11'h001;
              COL_INC_IX: if (row_select == ROW_PLAIN) ix_next = ix_reg + 4'h1;
              COL_BR_AR:  pc_next = ar_reg;
              COL_CALL_AR: begin
                push    = 1'b1;
                sp_next = sp_reg - 3'h1;
                pc_next = ar_reg;
              end
              COL_RET: begin
                pop     = 1'b1;
                pc_next = astack[sp_reg];
                sp_next = sp_reg + 3'h1;
                if (row_select == ROW_RETI)
                  isp_next = isp_reg - 3'h1;
              end
              COL_TBL: begin
                st_next = NID_ST_TBL2;
                pc_next = pc_reg;
              end
              default: ;
            endcase
          end
        end
        if (irq_enter)
          isp_next = isp_reg + 3'h1;
      end
      NID_ST_TBL2: begin
        dbf_next = insn;
        pc_next  = pc_reg + 11'h001;
        st_next  = NID_ST_RUN;
      end
      default: st_next = NID_ST_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= NID_ST_RUN;
      mem_addr_reg <= RST_ADDR7;
      reg_col_reg <= RST_NIB;
      imm_reg <= RST_NIB;
      mask_reg <= RST_NIB;
      per_reg <= RST_ADDR7;
      rf_reg <= RST_ADDR7;
      tgt_reg <= RST_PC;
      res_reg <= RST_NIB;
      wr_reg_reg <= 1'b0;
      wr_mem_reg <= 1'b0;
      cy_reg <= 1'b0;
      ar_reg <= RST_PC;
      ix_reg <= RST_NIB;
      pc_reg <= RST_PC;
      sp_reg <= RST_SP;
      dbf_reg <= 16'h0000;
      isp_reg <= RST_SP;
      ret_pc_reg <= RST_PC;
    end else begin
      st_reg <= st_next;
      mem_addr_reg <= mem_addr_next;
      reg_col_reg <= reg_col_next;
      imm_reg <= imm_next;
      mask_reg <= mask_next;
      per_reg <= per_next;
      rf_reg <= rf_next;
      tgt_reg <= tgt_next;
      res_reg <= res_next;
      wr_reg_reg <= wr_reg_next;
      wr_mem_reg <= wr_mem_next;
      cy_reg <= cy_next;
      ar_reg <= ar_next;
      ix_reg <= ix_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      dbf_reg <= dbf_next;
      isp_reg <= isp_next;
      ret_pc_reg <= pc_reg + 11'h001;
    end
  end

  // stacks hold no reset: contents are undefined until pushed
  always_ff @(posedge clk) begin
    if (push)
      astack[sp_reg - 3'h1] <= pc_reg + 11'h001;
    if (irq_enter && st_reg == NID_ST_RUN)
      istack[isp_reg] <= interrupt_saved_state;
  end

  assign insn_ready        = (st_reg == NID_ST_RUN);
  assign tbl_busy          = (st_reg == NID_ST_TBL2);
  assign mem_addr          = mem_addr_reg;
  assign reg_col           = reg_col_reg;
  assign imm_nibble        = imm_reg;
  assign bit_mask          = mask_reg;
  assign periph_addr       = per_reg;
  assign regfile_addr      = rf_reg;
  assign branch_target     = tgt_reg;
  assign result_reg        = res_reg;
  assign wr_reg            = wr_reg_reg;
  assign wr_mem            = wr_mem_reg;
  assign carry_flag        = cy_reg;
  assign address_register  = ar_reg;
  assign index_register    = ix_reg;
  assign stack_return_slot = astack[sp_reg];
  assign interrupt_saved_state_stack_top    = istack[isp_reg - 3'h1];
  assign data_buffer_reg   = dbf_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_target_msb_zero: assert property (@(posedge clk) disable iff (reset)
    branch_target[10] == 1'b0) else $error("target msb set");
  a_imm_low_nibble: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> imm_nibble == $past(insn[3:0])) else $error("immediate wrong");
  a_mask_field: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> bit_mask == $past(insn[3:0])) else $error("mask wrong");
  a_periph_addr: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> periph_addr == {$past(insn[10:8]), $past(insn[3:0])}) else $error("periph addr");
  a_regfile_addr: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> regfile_addr == {$past(insn[10:8]), $past(insn[3:0])}) else $error("rf addr");
  a_mem_addr: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> mem_addr == $past(insn[10:4])) else $error("mem addr");
  a_or_result: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && op == OP_OR_RM |=>
    wr_reg && result_reg == ($past(reg_nibble) | $past(mem_nibble))) else $error("or wrong");
  a_sub_mem: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && op == OP_SUB_MI |=>
    wr_mem && result_reg == $past(mem_nibble) - $past(insn[3:0])) else $error("sub wrong");
  a_add_carry_reg: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && op == OP_ADD_CARRY_RM |=> wr_reg &&
    {carry_flag, result_reg} == $past(reg_nibble) + $past(mem_nibble) + $past(carry_flag))
    else $error("add_carry wrong");
  a_subtract_borrow_mem: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && op == OP_SUBTRACT_BORROW_MI |=> wr_mem &&
    result_reg == 4'($past(mem_nibble) - $past(insn[3:0]) - $past(carry_flag)))
    else $error("subtract_borrow wrong");
  a_add_plain: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && op == OP_ADD_RM |=>
    result_reg == 4'($past(reg_nibble) + $past(mem_nibble))) else $error("add wrong");
  a_inc_ar: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && insn[15:4] == 12'h389 |=>
    address_register == $past(address_register) + 11'h001) else $error("inc ar");
  a_inc_ix: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && insn[15:4] == 12'h388 |=>
    index_register == $past(index_register) + 4'h1) else $error("inc ix");
  a_tbl_two_cycle: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && insn[15:4] == 12'h381 |=> tbl_busy ##1 insn_ready)
    else $error("table fetch length");
  a_call_push: assert property (@(posedge clk) disable iff (reset)
    insn_valid && insn_ready && op == OP_CALL |=>
    sp_reg == $past(sp_reg) - 3'h1 && stack_return_slot == $past(pc_reg) + 11'h001)
    else $error("call push");
  a_irq_save: assert property (@(posedge clk) disable iff (reset)
    irq_enter && insn_ready && !(insn_valid && op == OP_EXT && column_select == COL_RET
    && row_select == ROW_RETI) |=> interrupt_saved_state_stack_top == $past(interrupt_saved_state))
    else $error("irq save");
  c_add_carry: cover property (@(posedge clk) insn_valid && op == OP_ADD_CARRY_MI);
  c_tbl: cover property (@(posedge clk) tbl_busy);
  c_call_ret: cover property (@(posedge clk) insn_valid && op == OP_CALL ##[1:4]
    insn_valid && op == OP_EXT && column_select == COL_RET);
  c_irq: cover property (@(posedge clk) irq_enter);
endmodule

// ---- testbench/test_nibble_cpu_insn_decode.sv ----
// self-checking bench for the nibble core instruction decoder
`timescale 1ns/1ps
module test_nibble_cpu_insn_decode;
  import nid_pkg::*;
  // ---------------------------------------------------------------
  // design signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        reset;
  logic        insn_valid;
  logic [15:0] insn;
  logic [3:0]  reg_nibble;
  logic [3:0]  mem_nibble;
  logic        irq_enter;
  logic [3:0]  interrupt_saved_state;
  logic        insn_ready;
  logic [6:0]  mem_addr;
  logic [3:0]  reg_col;
  logic [3:0]  imm_nibble;
  logic [3:0]  bit_mask;
  logic [6:0]  periph_addr;
  logic [6:0]  regfile_addr;
  logic [10:0] branch_target;
  logic [3:0]  result_reg;
  logic        wr_reg;
  logic        wr_mem;
  logic        carry_flag;
  logic [10:0] address_register;
  logic [3:0]  index_register;
  logic [10:0] pc_reg;
  logic [10:0] stack_return_slot;
  logic [2:0]  sp_reg;
  logic [3:0]  interrupt_saved_state_stack_top;
  logic [15:0] data_buffer_reg;
  logic        tbl_busy;
  // ---------------------------------------------------------------
  // model state
  // ---------------------------------------------------------------
  int          err_total;
  int          total_checks;
  int          seed;
  int          i;
  logic        ex_on, ex_alu, ex_wr_reg, ex_wr_mem, cy, refuse, v;
  logic [15:0] ex_w, w, dw;
  logic [3:0]  ex_res, ix_m, r, m;
  logic [10:0] ar_m;
  logic [4:0]  ops [11];

  nid_decode u_nid_decode (
    .clk(clk), .reset(reset), .insn_valid(insn_valid), .insn(insn),
    .reg_nibble(reg_nibble), .mem_nibble(mem_nibble), .irq_enter(irq_enter),
    .interrupt_saved_state(interrupt_saved_state), .insn_ready(insn_ready),
    .mem_addr(mem_addr), .reg_col(reg_col), .imm_nibble(imm_nibble), .bit_mask(bit_mask),
    .periph_addr(periph_addr), .regfile_addr(regfile_addr), .branch_target(branch_target),
    .result_reg(result_reg), .wr_reg(wr_reg), .wr_mem(wr_mem), .carry_flag(carry_flag),
    .address_register(address_register), .index_register(index_register), .pc_reg(pc_reg),
    .stack_return_slot(stack_return_slot), .sp_reg(sp_reg), .interrupt_saved_state_stack_top(interrupt_saved_state_stack_top),
    .data_buffer_reg(data_buffer_reg), .tbl_busy(tbl_busy)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // compare tasks and closing
  // ---------------------------------------------------------------
  task automatic cmp_vec(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_vec(16'(got), 16'(exp));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // outputs answer one cycle after the word is taken
  task automatic check_prev;
    cmp_bit(wr_reg, ex_wr_reg);
    cmp_bit(wr_mem, ex_wr_mem);
    cmp_bit(carry_flag, cy);
    cmp_vec(16'(address_register), 16'(ar_m));
    cmp_vec(16'(index_register), 16'(ix_m));
    if (ex_alu) cmp_vec(16'(result_reg), 16'(ex_res));
    if (ex_on) begin
      cmp_vec(16'(mem_addr), 16'({ex_w[10:8], ex_w[7:4]}));
      cmp_vec(16'(imm_nibble), 16'(ex_w[3:0]));
      cmp_vec(16'(bit_mask), 16'(ex_w[3:0]));
      cmp_vec(16'(reg_col), 16'(ex_w[3:0]));
      cmp_vec(16'(periph_addr), 16'({ex_w[10:8], ex_w[3:0]}));
      cmp_vec(16'(regfile_addr), 16'({ex_w[10:8], ex_w[3:0]}));
      cmp_vec(16'(branch_target), 16'({1'b0, ex_w[9:0]}));
    end
  endtask

  // drives one cycle, checks the previous one, then models the new word
  task automatic exec(input logic [15:0] wd, input logic [3:0] rn, input logic [3:0] mn,
                      input logic vd, input logic irq, input logic [3:0] sv);
    logic [4:0] s;
    logic [4:0] op;
    logic [3:0] a;
    logic [3:0] b;
    logic       arith;
    @(posedge clk);
    insn_valid <= vd;
    insn <= wd;
    reg_nibble <= rn;
    mem_nibble <= mn;
    irq_enter <= irq;
    interrupt_saved_state <= sv;
    #1;
    check_prev();
    ex_on = vd && !refuse;
    ex_w = wd;
    ex_alu = 1'b0;
    ex_wr_reg = 1'b0;
    ex_wr_mem = 1'b0;
    op = wd[15:11];
    a = op[4] ? mn : rn;
    b = op[4] ? wd[3:0] : mn;
    s = 5'h00;
    arith = 1'b0;
    if (ex_on) begin
      case (op)
        OP_ADD_RM, OP_ADD_MI: begin s = {1'b0, a} + b; arith = 1'b1; end
        OP_ADD_CARRY_RM, OP_ADD_CARRY_MI: begin s = {1'b0, a} + b + cy; arith = 1'b1; end
        OP_SUB_RM, OP_SUB_MI: begin s = {1'b0, a} - b; arith = 1'b1; end
        OP_SUBTRACT_BORROW_RM, OP_SUBTRACT_BORROW_MI: begin s = {1'b0, a} - b - cy; arith = 1'b1; end
        OP_OR_RM: begin ex_alu = 1'b1; ex_res = rn | mn; ex_wr_reg = 1'b1; end
        OP_EXT: begin
          if (wd[10:8] == ROW_PLAIN && wd[7:4] == COL_INC_AR) ar_m = ar_m + 11'h001;
          if (wd[10:8] == ROW_PLAIN && wd[7:4] == COL_INC_IX) ix_m = ix_m + 4'h1;
        end
        default: ;
      endcase
      if (arith) begin
        ex_alu = 1'b1;
        ex_res = s[3:0];
        cy = s[4];
        ex_wr_reg = !op[4];
        ex_wr_mem = op[4];
      end
    end
  endtask
  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    #(25 * 5000);
    err_total++;
    final_report();
  end

  initial begin
    reset = 1'b1; insn_valid = 1'b0; insn = 16'h0000; reg_nibble = 4'h0; mem_nibble = 4'h0;
    irq_enter = 1'b0; interrupt_saved_state = 4'h0; err_total = 0; total_checks = 0;
    seed = 32'h3a6418a9; ex_on = 1'b0; ex_alu = 1'b0; ex_wr_reg = 1'b0; ex_wr_mem = 1'b0;
    cy = 1'b0; refuse = 1'b0; ar_m = 11'h000; ix_m = 4'h0; ex_w = 16'h0000; ex_res = 4'h0;
    ops = '{OP_ADD_RM, OP_SUB_RM, OP_ADD_CARRY_RM, OP_SUBTRACT_BORROW_RM, OP_OR_RM, OP_ADD_MI,
            OP_SUB_MI, OP_ADD_CARRY_MI, OP_SUBTRACT_BORROW_MI, OP_SKT, OP_SKF};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    cmp_vec(16'(pc_reg), 16'(RST_PC));
    cmp_vec(16'(sp_reg), 16'(RST_SP));
    cmp_bit(insn_ready, 1'b1);
    cmp_vec(data_buffer_reg, 16'h0000);
    check_prev();
    $display("test reset done");
    // random arithmetic, logic and bit test words, with bubbles
    for (i = 0; i < 300; i++) begin
      w = $random(seed);
      w[15:11] = ops[$unsigned($random(seed)) % 11];
      r = $random(seed);
      m = $random(seed);
      v = ($unsigned($random(seed)) % 6) != 0;
      exec(w, r, m, v, 1'b0, 4'h0);
    end
    $display("test random alu done");
    // index wraps past 4'hf; address register counts back to back
    for (i = 0; i < 18; i++) exec({OP_EXT, ROW_PLAIN, COL_INC_IX, 4'h0}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    for (i = 0; i < 3; i++) exec({OP_EXT, ROW_PLAIN, COL_INC_AR, 4'h0}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
    $display("test increment done");
    // table fetch: an add word offered in the second cycle is refused
    dw = {OP_ADD_RM, 11'h5a3};
    exec({OP_EXT, ROW_PLAIN, COL_TBL, 4'h0}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    refuse = 1'b1;
    exec(dw, 4'h7, 4'h9, 1'b1, 1'b0, 4'h0);
    refuse = 1'b0;
    cmp_bit(tbl_busy, 1'b1);
    cmp_bit(insn_ready, 1'b0);
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
    cmp_vec(data_buffer_reg, dw);
    cmp_bit(insn_ready, 1'b1);
    $display("test table fetch done");
    // branch, call and return through the address stack
    exec({OP_BR, 1'b0, 10'h155}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    exec({OP_CALL, 1'b0, 10'h2a0}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    cmp_vec(16'(pc_reg), 16'h0155);
    exec({OP_EXT, ROW_PLAIN, COL_RET, 4'h0}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    cmp_vec(16'(pc_reg), 16'h02a0);
    cmp_vec(16'(sp_reg), 16'h0007);
    cmp_vec(16'(stack_return_slot), 16'h0156);
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
    cmp_vec(16'(pc_reg), 16'h0156);
    cmp_vec(16'(sp_reg), 16'h0000);
    $display("test stack done");
    // interrupt entry pushes saved state, return pops it
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b1, 4'h6);
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b1, 4'hb);
    cmp_vec(16'(interrupt_saved_state_stack_top), 16'h0006);
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
    cmp_vec(16'(interrupt_saved_state_stack_top), 16'h000b);
    exec({OP_EXT, ROW_RETI, COL_RET, 4'h0}, 4'h0, 4'h0, 1'b1, 1'b0, 4'h0);
    exec(16'h0000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
    cmp_vec(16'(interrupt_saved_state_stack_top), 16'h0006);
    $display("test interrupt stack done");
    final_report();
  end
endmodule
